// *** verilog/srap_pkg.sv ***
/*
 constants, carriers and state types of the serial register access port.
 assumes one system clock that oversamples the serial clock by at least four.
*/
// Function
// - i2c write opens with address 111011 plus select-pin bit, direction bit zero
// - after write address, register address and data pairs follow until stop
// - read direction returns auto-incremented registers until master nack and stop
// - spi modes 00 and 11 chosen by clock level sampled after select falls
// - three-wire select makes data-in pin bidirectional, protocol otherwise unchanged
// - in three-wire operation the data output pin is never driven
// - spi data sampled on rising clock, output changed on falling clock
// - spi transaction runs while active-low select is low; clock steady at edges
// - spi control byte: bit 7 direction, lower seven bits register address
// - spi write is control and data pairs under one select, back to back
// - spi read: control byte, one dummy byte, then register data bytes
// - spi read advances register address by one after each data byte
// - any select low disables i2c until next power-on reset
// - i2c address low bit follows the address-select pin during operation
package srap_pkg;

   // ----------------------------------------------------------------
   // pin vector positions
   // ----------------------------------------------------------------
   localparam int PIN_SCK = 0;
   localparam int PIN_SDI = 1;
   localparam int PIN_CSB = 2;
   localparam int PIN_SA  = 3;
   localparam int PIN_W   = 4;
   // every pin idles high, so no false edge is seen right after reset
   localparam logic [PIN_W-1:0] PIN_IDLE = 4'hF;

   // ----------------------------------------------------------------
   // protocol constants
   // ----------------------------------------------------------------
   localparam logic [5:0] I2C_ADDR_HI  = 6'h3B;
   localparam logic [3:0] LAST_BIT     = 4'h7;
   localparam logic [3:0] BYTE_BITS    = 4'h8;
   localparam logic [3:0] CNT_STEP     = 4'h1;
   localparam int         RW_BIT       = 7;
   localparam logic       SPI_ADDR_MSB = 1'h1;
   localparam logic [7:0] ADDR_STEP    = 8'h01;
   localparam logic [7:0] DUMMY_BYTE   = 8'h00;

   // ----------------------------------------------------------------
   // carriers and states
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } srap_reg_req_type;

   typedef enum {SP_CTRL, SP_WDATA, SP_DUMMY, SP_RDATA} srap_spi_phase_type;
   typedef enum {I_IDLE, I_RX, I_ACK, I_LOAD, I_TX, I_MACK} srap_i2c_state_type;
   typedef enum {K_DEV, K_REG, K_DATA} srap_i2c_stage_type;

endpackage : srap_pkg

// *** verilog/srap_port.sv ***
/*
 serial register access port: i2c slave and 3/4-wire spi slave onto a
 simple register request bus.
 assumes reg_rdata is combinational from reg_req.addr, on the clk domain.
*/
`timescale 1ns/1ps
module srap_port (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   // serial pins
   input  wire logic                      sck_in,
   input  wire logic                      csb_n_in,
   input  wire logic                      sdi_in,
   output logic                           sdi_out,
   output logic                           sdi_oe,
   input  wire logic                      sdo_in,
   output logic                           sdo_out,
   output logic                           sdo_oe,
   // configuration and status
   input  wire logic                      three_wire_select,
   output logic                           spi_mode11,
   output logic                           i2c_disabled,
   // register side
   output srap_pkg::srap_reg_req_type     reg_req,
   input  wire logic [7:0]                reg_rdata
);
   import srap_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] pin_meta_reg;
   logic [PIN_W-1:0] pin_sync_reg;
   logic [PIN_W-1:0] pin_prev_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta_reg <= PIN_IDLE;
         pin_sync_reg <= PIN_IDLE;
         pin_prev_reg <= PIN_IDLE;
      end else begin
         pin_meta_reg <= {sdo_in, csb_n_in, sdi_in, sck_in};
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   logic               i2c_dis_reg,  i2c_dis_next;
   logic               mode11_reg,   mode11_next;
   srap_spi_phase_type phase_reg,    phase_next;
   srap_i2c_state_type ist_reg,      ist_next;
   srap_i2c_stage_type stage_reg,    stage_next;
   logic               i2c_rw_reg,   i2c_rw_next;
   logic [3:0]         cnt_reg,      cnt_next;
   logic [7:0]         rx_reg,       rx_next;
   logic [7:0]         tx_reg,       tx_next;
   logic               out_bit_reg,  out_bit_next;
   logic               sdo_oe_reg,   sdo_oe_next;
   logic               sdi_oe_reg,   sdi_oe_next;
   srap_reg_req_type   req_reg,      req_next;

   logic sck_rise;
   logic sck_fall;
   logic csb_fall;
   logic spi_act;
   logic i2c_en;
   logic i2c_start;
   logic i2c_stop;
   logic [7:0] rx_byte;

   assign sck_rise  = pin_sync_reg[PIN_SCK] & ~pin_prev_reg[PIN_SCK];
   assign sck_fall  = ~pin_sync_reg[PIN_SCK] & pin_prev_reg[PIN_SCK];
   assign csb_fall  = ~pin_sync_reg[PIN_CSB] & pin_prev_reg[PIN_CSB];
   assign spi_act   = ~pin_sync_reg[PIN_CSB];
   // clock steady while select moves, so a select edge never doubles as a clock edge
   assign i2c_en    = ~i2c_dis_reg & pin_sync_reg[PIN_CSB];
   assign i2c_start = i2c_en & pin_sync_reg[PIN_SCK] & pin_prev_reg[PIN_SCK]
                      & ~pin_sync_reg[PIN_SDI] & pin_prev_reg[PIN_SDI];
   assign i2c_stop  = i2c_en & pin_sync_reg[PIN_SCK] & pin_prev_reg[PIN_SCK]
                      & pin_sync_reg[PIN_SDI] & ~pin_prev_reg[PIN_SDI];
   assign rx_byte   = {rx_reg[6:0], pin_sync_reg[PIN_SDI]};

   // ----------------------------------------------------------------
   // protocol engine
   // ----------------------------------------------------------------
   always_comb begin
      i2c_dis_next = i2c_dis_reg;
      mode11_next  = mode11_reg;
      phase_next   = phase_reg;
      ist_next     = ist_reg;
      stage_next   = stage_reg;
      i2c_rw_next  = i2c_rw_reg;
      cnt_next     = cnt_reg;
      rx_next      = rx_reg;
      tx_next      = tx_reg;
      out_bit_next = out_bit_reg;
      sdo_oe_next  = 1'h0;
      sdi_oe_next  = sdi_oe_reg;
      req_next     = req_reg;
      req_next.wr  = 1'h0;
      req_next.rd  = 1'h0;
      if (req_reg.rd) begin
         req_next.addr = req_reg.addr + ADDR_STEP;
      end
      if (csb_fall) begin
         i2c_dis_next = 1'h1;
         mode11_next  = pin_sync_reg[PIN_SCK];
         phase_next   = SP_CTRL;
         ist_next     = I_IDLE;
         cnt_next     = 4'h0;
         tx_next      = DUMMY_BYTE;
         out_bit_next = 1'h0;
         sdi_oe_next  = 1'h0;
      end else if (spi_act) begin
         if (sck_rise) begin
            rx_next  = rx_byte;
            cnt_next = cnt_reg + CNT_STEP;
            if (cnt_reg == LAST_BIT) begin
               cnt_next = 4'h0;
               case (phase_reg)
                  SP_CTRL: begin
                     req_next.addr = {SPI_ADDR_MSB, rx_byte[6:0]};
                     phase_next    = rx_byte[RW_BIT] ? SP_DUMMY : SP_WDATA;
                  end
                  SP_WDATA: begin
                     req_next.wdata = rx_byte;
                     req_next.wr    = 1'h1;
                     phase_next     = SP_CTRL;
                  end
                  default: begin
                     // dummy or data byte ends here, so the next data byte is loaded now
                     tx_next     = reg_rdata;
                     req_next.rd = 1'h1;
                     phase_next  = SP_RDATA;
                  end
               endcase
            end
         end else if (sck_fall) begin
            out_bit_next = tx_reg[7];
            tx_next      = {tx_reg[6:0], 1'h0};
            // turn the shared pin round on a falling edge, once the host has let go
            sdi_oe_next  = three_wire_select
                           & (phase_reg == SP_DUMMY || phase_reg == SP_RDATA);
         end
         sdo_oe_next = ~three_wire_select;
      end else if (!i2c_en) begin
         sdi_oe_next = 1'h0;
      end else if (i2c_stop) begin
         ist_next    = I_IDLE;
         sdi_oe_next = 1'h0;
      end else if (i2c_start) begin
         ist_next    = I_RX;
         stage_next  = K_DEV;
         cnt_next    = 4'h0;
         sdi_oe_next = 1'h0;
      end else begin
         case (ist_reg)
            I_RX: begin
               if (sck_rise) begin
                  rx_next  = rx_byte;
                  cnt_next = cnt_reg + CNT_STEP;
                  if (cnt_reg == LAST_BIT) begin
                     cnt_next = 4'h0;
                     ist_next = I_ACK;
                     case (stage_reg)
                        K_DEV: begin
                           if (rx_byte[7:1] == {I2C_ADDR_HI,
                                                pin_sync_reg[PIN_SA]}) begin
                              i2c_rw_next = rx_byte[0];
                              stage_next  = K_REG;
                           end else begin
                              ist_next = I_IDLE;
                           end
                        end
                        K_REG: begin
                           req_next.addr = rx_byte;
                           stage_next    = K_DATA;
                        end
                        default: begin
                           req_next.wdata = rx_byte;
                           req_next.wr    = 1'h1;
                           stage_next     = K_REG;
                        end
                     endcase
                  end
               end
            end
            I_ACK: begin
               if (sck_fall) begin
                  sdi_oe_next = 1'h1;
                  ist_next    = I_LOAD;
               end
            end
            I_LOAD: begin
               if (sck_fall) begin
                  if (i2c_rw_reg) begin
                     tx_next     = {reg_rdata[6:0], 1'h0};
                     sdi_oe_next = ~reg_rdata[7];
                     req_next.rd = 1'h1;
                     cnt_next    = 4'h0;
                     ist_next    = I_TX;
                  end else begin
                     sdi_oe_next = 1'h0;
                     ist_next    = I_RX;
                  end
               end
            end
            I_TX: begin
               if (sck_rise) begin
                  cnt_next = cnt_reg + CNT_STEP;
               end else if (sck_fall) begin
                  if (cnt_reg == BYTE_BITS) begin
                     sdi_oe_next = 1'h0;
                     ist_next    = I_MACK;
                  end else begin
                     sdi_oe_next = ~tx_reg[7];
                     tx_next     = {tx_reg[6:0], 1'h0};
                  end
               end
            end
            I_MACK: begin
               if (sck_rise) begin
                  ist_next = pin_sync_reg[PIN_SDI] ? I_IDLE : I_LOAD;
               end
            end
            default: begin
               sdi_oe_next = 1'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         i2c_dis_reg <= 1'h0;
         mode11_reg  <= 1'h0;
         phase_reg   <= SP_CTRL;
         ist_reg     <= I_IDLE;
         stage_reg   <= K_DEV;
         i2c_rw_reg  <= 1'h0;
         cnt_reg     <= 4'h0;
         rx_reg      <= 8'h00;
         tx_reg      <= 8'h00;
         out_bit_reg <= 1'h0;
         sdo_oe_reg  <= 1'h0;
         sdi_oe_reg  <= 1'h0;
         req_reg     <= '0;
      end else begin
         i2c_dis_reg <= i2c_dis_next;
         mode11_reg  <= mode11_next;
         phase_reg   <= phase_next;
         ist_reg     <= ist_next;
         stage_reg   <= stage_next;
         i2c_rw_reg  <= i2c_rw_next;
         cnt_reg     <= cnt_next;
         rx_reg      <= rx_next;
         tx_reg      <= tx_next;
         out_bit_reg <= out_bit_next;
         sdo_oe_reg  <= sdo_oe_next;
         sdi_oe_reg  <= sdi_oe_next;
         req_reg     <= req_next;
      end
   end

   // i2c drives only low, and out_bit stays zero until spi, which locks i2c out
   assign sdi_out      = out_bit_reg;
   assign sdi_oe       = sdi_oe_reg;
   assign sdo_out      = out_bit_reg;
   assign sdo_oe       = sdo_oe_reg;
   assign spi_mode11   = mode11_reg;
   assign i2c_disabled = i2c_dis_reg;
   assign reg_req      = req_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence ctrl_read_seq;
      spi_act && sck_rise && cnt_reg == LAST_BIT && phase_reg == SP_CTRL && rx_byte[RW_BIT];
   endsequence

   i2c_lock_holds_a: assert property (i2c_dis_reg |=> i2c_dis_reg)
      else $error("i2c came back after select went low");
   i2c_lock_sets_a: assert property (csb_fall |=> i2c_dis_reg)
      else $error("select fall did not disable i2c");
   spi_mode_pick_a: assert property (csb_fall
                                     |=> mode11_reg == $past(pin_sync_reg[PIN_SCK]))
      else $error("spi mode not taken from clock level");
   three_wire_sdo_a: assert property (three_wire_select
                                      && $past(three_wire_select) |-> !sdo_oe)
      else $error("data output driven in three-wire operation");
   csb_high_release_a: assert property (!spi_act ##1 !spi_act |-> !sdo_oe)
      else $error("data output driven with select high");
   dummy_follows_a: assert property (ctrl_read_seq
                                     |=> phase_reg == SP_DUMMY ##0 !req_reg.rd)
      else $error("read control byte not followed by dummy byte");
   addr_step_a: assert property (req_reg.rd
                                 |=> req_reg.addr == $past(req_reg.addr) + ADDR_STEP)
      else $error("register address did not advance after read");
   spi_write_pair_a: assert property (spi_act && req_reg.wr
                                      |-> req_reg.addr[RW_BIT] == SPI_ADDR_MSB
                                      && phase_reg == SP_CTRL)
      else $error("spi write outside a control and data pair");
   i2c_idle_free_a: assert property (i2c_en && ist_reg == I_IDLE
                                     && $past(ist_reg) == I_IDLE |-> !sdi_oe)
      else $error("bus held while i2c idle");

endmodule : srap_port

// *** bench/srap_host.sv ***
/*
 host model: an spi or i2c master driving clock, select and data pins.
 assumes the bench resolves the shared data line with a pull-up.
*/
`timescale 1ns/1ps
module srap_host (
   // clock
   input  wire logic clk,
   // driven pins
   output logic      sck,
   output logic      csb_n,
   output logic      mosi_oe,
   output logic      mosi,
   // observed lines
   input  wire logic sdi_line,
   input  wire logic sdo_line
);
   // ----------------------------------------------------------------
   // link tasks, every move on a falling clk edge
   // ----------------------------------------------------------------
   initial begin
      sck = 1'b1;
      csb_n = 1'b1;
      mosi_oe = 1'b0;
      mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   // open drain: drive low or release; data moves one clk after scl falls
   task automatic i2c_bit(input logic b, output logic r);
      mosi_oe = ~b;
      tick(3);
      sck = 1'b1;
      tick(2);
      r = sdi_line;
      tick(2);
      sck = 1'b0;
      tick(1);
   endtask : i2c_bit
   task automatic i2c_byte(input logic [7:0] tx, input logic mack,
                           output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
      i2c_bit(mack, ack);
   endtask : i2c_byte
   // also serves as repeated start: sda released while scl is low
   task automatic i2c_start;
      mosi_oe = 1'b0;
      tick(4);
      sck = 1'b1;
      tick(4);
      mosi_oe = 1'b1;
      tick(4);
      sck = 1'b0;
      tick(1);
   endtask : i2c_start
   task automatic i2c_stop;
      mosi_oe = 1'b1;
      tick(3);
      sck = 1'b1;
      tick(4);
      mosi_oe = 1'b0;
      tick(4);
   endtask : i2c_stop
   // clock parked at its idle level while select moves
   task automatic spi_sel(input logic idle, input logic lvl);
      sck = idle;
      tick(6);
      csb_n = lvl;
      tick(6);
   endtask : spi_sel
   task automatic spi_byte(input logic [7:0] tx, input logic drive, input logic three,
                           output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         mosi_oe = drive;
         mosi = tx[i];
         tick(4);
         sck = 1'b1;
         rx[i] = three ? sdi_line : sdo_line;
         tick(4);
      end
   endtask : spi_byte
endmodule : srap_host

// *** bench/srap_port_tb_top.sv ***
/*
 self-checking bench of the serial register access port: i2c, spi in
 both modes and wirings, then i2c lock-out and a second reset.
 assumes the host model and a register array in place of device registers.
*/
`timescale 1ns/1ps
module srap_port_tb_top;
   import srap_pkg::*;
   logic             clk, rst_b, three_wire_select, sa_lvl;
   logic             sck, csb_n, mosi_oe, mosi, sdi_line, sdo_in, sdo_line;
   logic             sdi_out, sdi_oe, sdo_out, sdo_oe, spi_mode11, i2c_disabled;
   logic [7:0]       reg_rdata;
   logic [7:0]       mem [256];
   srap_reg_req_type reg_req;
   int               miscompares = 0;
   int               comparisons = 0;
   int               sdo3_hits = 0;

   // pull-up on the shared line; released sdo shows the inverse of its last bit
   assign sdi_line  = ~((sdi_oe & ~sdi_out) | (mosi_oe & ~mosi));
   assign sdo_in    = sdo_oe ? sdo_out : sa_lvl;
   assign sdo_line  = sdo_oe ? sdo_out : ~sdo_out;
   assign reg_rdata = mem[reg_req.addr];

   srap_port srap_port_inst (.clk(clk), .rst_b(rst_b), .sck_in(sck), .csb_n_in(csb_n),
      .sdi_in(sdi_line), .sdi_out(sdi_out), .sdi_oe(sdi_oe), .sdo_in(sdo_in),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe), .three_wire_select(three_wire_select),
      .spi_mode11(spi_mode11), .i2c_disabled(i2c_disabled), .reg_req(reg_req),
      .reg_rdata(reg_rdata));
   srap_host srap_host_inst (.clk(clk), .sck(sck), .csb_n(csb_n), .mosi_oe(mosi_oe),
      .mosi(mosi), .sdi_line(sdi_line), .sdo_line(sdo_line));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      if (reg_req.wr === 1'b1) mem[reg_req.addr] <= reg_req.wdata;
      if (three_wire_select === 1'b1 && sdo_oe !== 1'b0) sdo3_hits <= sdo3_hits + 1;
   end

   // ----------------------------------------------------------------
   // checking and verdict
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict;
      if (miscompares == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic i2c_scn;
      logic [7:0] rx;
      logic       ack;
      logic [7:0] wr [5] = '{8'hEC, 8'h10, 8'h3C, 8'h11, 8'hC3};
      sa_lvl = 1'b0;
      srap_host_inst.i2c_start();
      foreach (wr[i]) begin
         srap_host_inst.i2c_byte(wr[i], 1'b1, rx, ack);
         check({7'h0, ack}, 8'h00);
      end
      srap_host_inst.i2c_stop();
      check(mem[8'h10], 8'h3C);
      check(mem[8'h11], 8'hC3);
      sa_lvl = 1'b1;
      srap_host_inst.i2c_start();
      srap_host_inst.i2c_byte(8'hEE, 1'b1, rx, ack);
      check({7'h0, ack}, 8'h00);
      srap_host_inst.i2c_byte(8'h10, 1'b1, rx, ack);
      srap_host_inst.i2c_start();
      srap_host_inst.i2c_byte(8'hEF, 1'b1, rx, ack);
      check({7'h0, ack}, 8'h00);
      srap_host_inst.i2c_byte(8'hFF, 1'b0, rx, ack);
      check(rx, 8'h3C);
      srap_host_inst.i2c_byte(8'hFF, 1'b1, rx, ack);
      check(rx, 8'hC3);
      srap_host_inst.i2c_stop();
      srap_host_inst.i2c_start();
      srap_host_inst.i2c_byte(8'hEC, 1'b1, rx, ack);
      check({7'h0, ack}, 8'h01);
      srap_host_inst.i2c_stop();
      check({7'h0, i2c_disabled}, 8'h00);
   endtask : i2c_scn

   task automatic spi_scn(input logic idle, input logic three, input logic [7:0] base);
      logic [7:0] rx;
      logic [7:0] exp [3];
      int         hits_at_start;
      exp = '{base, base + 8'h01, 8'h06};
      three_wire_select = three;
      hits_at_start = sdo3_hits;
      srap_host_inst.spi_sel(idle, 1'b0);
      check({7'h0, spi_mode11}, {7'h0, idle});
      check({7'h0, i2c_disabled}, 8'h01);
      for (int i = 0; i < 2; i++) begin
         srap_host_inst.spi_byte(8'h21 + 8'(i), 1'b1, three, rx);
         srap_host_inst.spi_byte(base + 8'(i), 1'b1, three, rx);
      end
      srap_host_inst.spi_sel(idle, 1'b1);
      check(mem[8'hA1], base);
      check(mem[8'hA2], base + 8'h01);
      check({7'h0, sdo_oe}, 8'h00);
      srap_host_inst.spi_sel(idle, 1'b0);
      srap_host_inst.spi_byte(8'hA1, 1'b1, three, rx);
      srap_host_inst.spi_byte(8'h00, ~three, three, rx);
      for (int i = 0; i < 3; i++) begin
         srap_host_inst.spi_byte(8'h00, ~three, three, rx);
         check(rx, exp[i]);
      end
      srap_host_inst.spi_sel(idle, 1'b1);
      check({7'h0, sdo3_hits != hits_at_start}, 8'h00);
   endtask : spi_scn

   task automatic lock_scn;
      logic [7:0] rx;
      logic       ack;
      three_wire_select = 1'b0;
      sa_lvl = 1'b0;
      srap_host_inst.i2c_start();
      srap_host_inst.i2c_byte(8'hEC, 1'b1, rx, ack);
      check({7'h0, ack}, 8'h01);
      srap_host_inst.i2c_stop();
      rst_b = 1'b0;
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      check({7'h0, i2c_disabled}, 8'h00);
      srap_host_inst.i2c_start();
      srap_host_inst.i2c_byte(8'hEC, 1'b1, rx, ack);
      check({7'h0, ack}, 8'h00);
      srap_host_inst.i2c_stop();
   endtask : lock_scn

   initial begin
      rst_b = 1'b0;
      three_wire_select = 1'b0;
      sa_lvl = 1'b0;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      i2c_scn();
      spi_scn(1'b0, 1'b0, 8'h5A);
      spi_scn(1'b1, 1'b0, 8'h96);
      spi_scn(1'b0, 1'b1, 8'h3D);
      spi_scn(1'b1, 1'b1, 8'hC6);
      lock_scn();
      print_verdict();
   end
   // hang guard: a run this long is counted as a failure
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      print_verdict();
   end
endmodule : srap_port_tb_top
